// [swt_ctrl.sv]
// Sleep and wake timing controller: parameter store, sleep sequencing and counters
//
// Functional notes
// - Mode 0 never sleeps, 1 pin sleep, 4 cyclic, 5 cyclic with pin wake.
// - Sleep interval counted in 10 ms units, 1 to 0x83D600, reset 0xC8.
// - Option bit 6 keeps the access point association through sleep.
// - Option 0x100 means receptions never restart the awake timer; reset value.
// - Nonzero host-wake delay holds off serial output and samples after waking.
// - Serial character from host during the delay stops the delay at once.
// - Cyclic awake window in ms, 1 to 0x36EE80, reset 0x7D0, reloaded at each wake.
// - Pending transmit or receive work finishes before sleep is entered.
// - Wait up to the join timeout for association before deep sleep.
`timescale 1ns/100ps
`include "swt_consts.svh"
module swt_ctrl
	import swt_pkg::*;
#(
	parameter int MS_CYCLES = `SWT_MS_CYCLES
)
(
	input wire logic ref_clk, // System clock, 40 MHz
	input wire logic rstn, // Synchronous reset, active low
	input wire logic cfgWrite, // Settings write strobe
	input wire logic [2:0] cfgSel, // Settings selector
	input wire logic [23:0] cfgData, // Settings write data
	input wire logic cfgApply, // Commit pending settings
	output logic [23:0] cfgRdata, // Value in force for cfgSel
	input wire logic sleepPin, // Sleep request pin, high asks for sleep
	input wire logic hostChar, // Serial character received from host
	input wire logic workPending, // Transmit or receive work outstanding
	input wire logic associated, // Joined to access point
	output logic asleep, // Module sleeping
	output logic keepAssoc, // Hold association while sleeping
	output logic hostHold, // Hold off serial output and io samples
	output logic deepSleep // Sleeping without association
);
	// ----------------------------------------
	// Pending and active settings
	// ----------------------------------------
	logic [7:0] penMode_r, actMode_r;
	logic [23:0] penPeriod_r, actPeriod_r;
	logic [15:0] penOpt_r, actOpt_r;
	logic [15:0] penHost_r, actHost_r;
	logic [23:0] penWake_r, actWake_r;
	logic [23:0] penJoin_r, actJoin_r;

	function automatic logic [23:0] clampMs(input logic [23:0] v, input logic [23:0] hi);
		clampMs = (v == 24'h000000) ? 24'h000001 : ((v > hi) ? hi : v);
	endfunction : clampMs

	// Saturating step down, so a late tick can never wrap a counter
	function automatic logic [23:0] cntDec(input logic [23:0] c);
		cntDec = (c == 24'h000000) ? c : c - 24'h000001;
	endfunction : cntDec

	wire wrMode = cfgWrite && cfgSel == `SWT_SEL_MODE;
	wire wrPeriod = cfgWrite && cfgSel == `SWT_SEL_PERIOD;
	wire wrOpt = cfgWrite && cfgSel == `SWT_SEL_OPTIONS;
	wire wrHost = cfgWrite && cfgSel == `SWT_SEL_HOSTDLY;
	wire wrWake = cfgWrite && cfgSel == `SWT_SEL_WAKE;
	wire wrJoin = cfgWrite && cfgSel == `SWT_SEL_JOIN;
	// Unsupported mode codes are kept out so the sequencer never sees them
	wire modeLegal = cfgData[7:0] == SWT_MODE_NONE || cfgData[7:0] == SWT_MODE_PIN ||
		cfgData[7:0] == SWT_MODE_CYCLIC || cfgData[7:0] == SWT_MODE_CYCLIC_PIN;
	// Clearing the no-restart bit is unsupported; it is forced on
	wire [15:0] optIn = (cfgData[15:0] & `SWT_MAX_OPTIONS) | (16'h0001 << `SWT_OPT_NO_RESTART);

	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			penMode_r <= `SWT_RST_MODE;
			penPeriod_r <= `SWT_RST_PERIOD;
			penOpt_r <= `SWT_RST_OPTIONS;
			penHost_r <= `SWT_RST_HOSTDLY;
			penWake_r <= `SWT_RST_WAKE;
			penJoin_r <= `SWT_RST_JOIN;
		end
		else
		begin
			if (wrMode && modeLegal)
				penMode_r <= cfgData[7:0];
			if (wrPeriod)
				penPeriod_r <= clampMs(cfgData, `SWT_MAX_PERIOD);
			if (wrOpt)
				penOpt_r <= optIn;
			if (wrHost)
				penHost_r <= cfgData[15:0];
			if (wrWake)
				penWake_r <= clampMs(cfgData, `SWT_MAX_WAKE);
			if (wrJoin)
				penJoin_r <= clampMs(cfgData, `SWT_MAX_JOIN);
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			actMode_r <= `SWT_RST_MODE;
			actPeriod_r <= `SWT_RST_PERIOD;
			actOpt_r <= `SWT_RST_OPTIONS;
			actHost_r <= `SWT_RST_HOSTDLY;
			actWake_r <= `SWT_RST_WAKE;
			actJoin_r <= `SWT_RST_JOIN;
		end
		else if (cfgApply)
		begin
			actMode_r <= penMode_r;
			actPeriod_r <= penPeriod_r;
			actOpt_r <= penOpt_r;
			actHost_r <= penHost_r;
			actWake_r <= penWake_r;
			actJoin_r <= penJoin_r;
		end
	end

	// ----------------------------------------
	// Readback of values in force
	// ----------------------------------------
	// Shows the values in force, never the pending ones
	logic [23:0] rdSel;
	always_comb
	begin
		unique case (cfgSel)
			`SWT_SEL_MODE: rdSel = {16'h0000, actMode_r};
			`SWT_SEL_PERIOD: rdSel = actPeriod_r;
			`SWT_SEL_OPTIONS: rdSel = {8'h00, actOpt_r};
			`SWT_SEL_HOSTDLY: rdSel = {8'h00, actHost_r};
			`SWT_SEL_WAKE: rdSel = actWake_r;
			`SWT_SEL_JOIN: rdSel = actJoin_r;
			default: rdSel = 24'h000000;
		endcase
	end

	// ----------------------------------------
	// Pin synchronisers, three stages
	// ----------------------------------------
	logic [2:0] pinSync_r;
	logic pinLvl_r;
	wire pinAgree = pinSync_r[1] == pinSync_r[2];
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			pinSync_r <= 3'h0;
			pinLvl_r <= 1'b0;
		end
		else
		begin
			pinSync_r <= {pinSync_r[1:0], sleepPin};
			// Level moves only once the last two stages agree
			if (pinAgree)
				pinLvl_r <= pinSync_r[2];
		end
	end

	// ----------------------------------------
	// Ticks
	// ----------------------------------------
	logic msTick, slotTick;
	swt_tick #(.MS_CYCLES(MS_CYCLES), .MS_PER_SLOT(`SWT_MS_PER_SLOT)) uTick
	(
		.ref_clk(ref_clk),
		.rstn(rstn),
		.msTick(msTick),
		.slotTick(slotTick)
	);

	// ----------------------------------------
	// Sleep sequencer
	// ----------------------------------------
	swt_state_t state_r, state_nxt;
	logic [23:0] cnt_r, cnt_nxt;
	logic [23:0] joinCnt_r;
	logic joinGaveUp_r;
	wire cyclic = actMode_r == SWT_MODE_CYCLIC || actMode_r == SWT_MODE_CYCLIC_PIN;
	wire pinMode = actMode_r == SWT_MODE_PIN;
	wire pinWake = actMode_r == SWT_MODE_CYCLIC_PIN && !pinLvl_r;
	// Counts run down to zero, so a setting of n spans n ticks
	wire cntDone = cnt_r == 24'h000000;
	// Association wait runs while awake; a give-up allows deep sleep
	wire joinOk = associated || joinGaveUp_r;
	wire wantSleep = (pinMode && pinLvl_r) || (cyclic && cntDone);

	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		unique case (state_r)
			SWT_AWAKE:
			begin
				// Not restarted by traffic: option bit forced set
				if (cyclic && msTick && !cntDone)
					cnt_nxt = cntDec(cnt_r);
				if (actMode_r == SWT_MODE_NONE)
					cnt_nxt = actWake_r;
				else if (wantSleep && joinOk)
				begin
					state_nxt = SWT_DRAIN;
				end
			end
			SWT_DRAIN:
			begin
				// Pending work holds off sleep however long it takes
				if (!workPending)
				begin
					state_nxt = SWT_SLEEP;
					cnt_nxt = actPeriod_r;
				end
			end
			SWT_SLEEP:
			begin
				if (cyclic && slotTick && !cntDone)
					cnt_nxt = cntDec(cnt_r);
				// Pin wake and period expiry both end sleep
				if (actMode_r == SWT_MODE_NONE || (pinMode && !pinLvl_r) || pinWake ||
					(cyclic && cntDone))
				begin
					state_nxt = (actHost_r != 16'h0000) ? SWT_HOSTDLY : SWT_RUN;
					cnt_nxt = (actHost_r != 16'h0000) ? {8'h00, actHost_r} : actWake_r;
				end
			end
			SWT_HOSTDLY:
			begin
				if (msTick)
					cnt_nxt = cntDec(cnt_r);
				// Any host character ends the wait early
				if (hostChar || cntDone)
				begin
					state_nxt = SWT_RUN;
					cnt_nxt = actWake_r;
				end
			end
			SWT_RUN:
			begin
				state_nxt = SWT_AWAKE;
			end
			default:
			begin
				state_nxt = SWT_AWAKE;
				cnt_nxt = actWake_r;
			end
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			state_r <= SWT_AWAKE;
			cnt_r <= `SWT_RST_WAKE;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Join wait restarts each time the module wakes
	// A new timeout setting is picked up at the next wake only
	always_ff @(posedge ref_clk)
	begin
		if (!rstn || state_r == SWT_SLEEP)
		begin
			joinCnt_r <= `SWT_RST_JOIN;
			joinGaveUp_r <= 1'b0;
		end
		else if (state_r == SWT_RUN)
		begin
			joinCnt_r <= actJoin_r;
			joinGaveUp_r <= 1'b0;
		end
		else if (!associated && msTick && !joinGaveUp_r)
		begin
			joinCnt_r <= cntDec(joinCnt_r);
			joinGaveUp_r <= joinCnt_r <= 24'h000001;
		end
	end

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			asleep <= 1'b0;
			keepAssoc <= 1'b0;
			hostHold <= 1'b0;
			deepSleep <= 1'b0;
			cfgRdata <= 24'h000000;
		end
		else
		begin
			asleep <= state_nxt == SWT_SLEEP;
			keepAssoc <= state_nxt == SWT_SLEEP && actOpt_r[`SWT_OPT_STAY_ASSOC];
			// Deep sleep drops association; slower wake is the price of the lower current
			deepSleep <= state_nxt == SWT_SLEEP && !actOpt_r[`SWT_OPT_STAY_ASSOC];
			// Hold covers sleep too, so nothing leaves before the delay
			hostHold <= state_nxt == SWT_HOSTDLY || state_nxt == SWT_SLEEP;
			cfgRdata <= rdSel;
		end
	end
endmodule : swt_ctrl

// [swt_consts.svh]
// Offsets, reset values and timing counts of the sleep and wake timing controller
`ifndef SWT_CONSTS_SVH
`define SWT_CONSTS_SVH
// Parameter selectors on the settings write port (indices, not byte addresses)
`define SWT_SEL_MODE 3'h0
`define SWT_SEL_PERIOD 3'h1
`define SWT_SEL_OPTIONS 3'h2
`define SWT_SEL_HOSTDLY 3'h3
`define SWT_SEL_WAKE 3'h4
`define SWT_SEL_JOIN 3'h5
// Reset values
`define SWT_RST_MODE 8'h00
`define SWT_RST_PERIOD 24'h0000c8
`define SWT_RST_OPTIONS 16'h0100
`define SWT_RST_HOSTDLY 16'h0000
`define SWT_RST_WAKE 24'h0007d0
`define SWT_RST_JOIN 24'h002710
// Ranges
`define SWT_MAX_PERIOD 24'h83d600
`define SWT_MAX_OPTIONS 16'h01ff
`define SWT_MAX_WAKE 24'h36ee80
`define SWT_MAX_JOIN 24'h36ee80
// Option bits
`define SWT_OPT_STAY_ASSOC 6
`define SWT_OPT_NO_RESTART 8
// Timing
`define SWT_CLK_HZ 40000000
`define SWT_TICK_MS 1
`define SWT_MS_CYCLES (`SWT_CLK_HZ / 1000 * `SWT_TICK_MS)
`define SWT_MS_PER_SLOT 10
`endif

// [swt_pkg.sv]
// Types of the sleep and wake timing controller
package swt_pkg;
	typedef enum logic [7:0]
	{
		SWT_MODE_NONE = 8'h00,
		SWT_MODE_PIN = 8'h01,
		SWT_MODE_CYCLIC = 8'h04,
		SWT_MODE_CYCLIC_PIN = 8'h05
	} swt_mode_t;
	typedef enum logic [2:0]
	{
		SWT_AWAKE = 3'b000,
		SWT_HOSTDLY = 3'b001,
		SWT_RUN = 3'b011,
		SWT_DRAIN = 3'b010,
		SWT_SLEEP = 3'b110
	} swt_state_t;
endpackage : swt_pkg

// [swt_tick.sv]
// Millisecond and ten-millisecond tick generator
`timescale 1ns/100ps
`include "swt_consts.svh"
module swt_tick
#(
	parameter int MS_CYCLES = `SWT_MS_CYCLES,
	parameter int MS_PER_SLOT = `SWT_MS_PER_SLOT
)
(
	input wire logic ref_clk, // System clock
	input wire logic rstn, // Synchronous reset, active low
	output logic msTick, // One cycle each millisecond
	output logic slotTick // One cycle each ten milliseconds
);
	logic [15:0] cycCnt_r;
	logic [3:0] msCnt_r;
	wire cycWrap = (cycCnt_r == 16'(MS_CYCLES - 1));
	wire slotWrap = (msCnt_r == 4'(MS_PER_SLOT - 1));
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			cycCnt_r <= 16'h0000;
			msCnt_r <= 4'h0;
			msTick <= 1'b0;
			slotTick <= 1'b0;
		end
		else
		begin
			cycCnt_r <= cycWrap ? 16'h0000 : cycCnt_r + 16'h0001;
			msTick <= cycWrap;
			slotTick <= cycWrap && slotWrap;
			if (cycWrap)
				msCnt_r <= slotWrap ? 4'h0 : msCnt_r + 4'h1;
		end
	end
endmodule : swt_tick

// [swt_host_model.sv]
// Host processor model driving the settings port and serial characters
`timescale 1ns/100ps
module swt_host_model
(
	input wire logic ref_clk, // Clock
	input wire logic reqWr, // Write request
	input wire logic reqApply, // Commit request
	input wire logic reqChar, // Character request
	input wire logic [2:0] reqSel, // Selector
	input wire logic [23:0] reqData, // Data
	output logic cfgWrite, // Write strobe
	output logic cfgApply, // Commit strobe
	output logic hostChar, // Serial character
	output logic [2:0] cfgSel, // Selector
	output logic [23:0] cfgData // Data
);
	always_ff @(posedge ref_clk)
	begin
		cfgWrite <= reqWr;
		cfgApply <= reqApply;
		hostChar <= reqChar;
		cfgSel <= reqSel;
		// Host never sets unused option bits
		cfgData <= (reqSel == 3'h2) ? (reqData & 24'h0001ff) : reqData;
	end
endmodule : swt_host_model

// [swt_ctrl_monitor.sv]
// Assertion checker for the sleep and wake timing controller
`timescale 1ns/100ps
module swt_ctrl_monitor
#(
	parameter int MS_CYCLES = 40000
)
(
	input wire logic ref_clk, // Clock
	input wire logic rstn, // Reset
	input wire logic cfgWrite, // Write
	input wire logic [2:0] cfgSel, // Selector
	input wire logic [23:0] cfgData, // Data
	input wire logic cfgApply, // Commit
	input wire logic [23:0] cfgRdata, // Readback
	input wire logic sleepPin, // Pin
	input wire logic hostChar, // Char
	input wire logic workPending, // Work
	input wire logic associated, // Joined
	input wire logic asleep, // Sleeping
	input wire logic keepAssoc, // Keep join
	input wire logic hostHold, // Hold host
	input wire logic deepSleep // Deep
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);
	// ------
	// Checks
	// ------
	property rdRange(s, lo, hi);
		$past(rstn) && $past(cfgSel) == s |-> cfgRdata >= lo && cfgRdata <= hi;
	endproperty
	keep_awake_a: assert property (keepAssoc |-> asleep && !deepSleep) else $error("keep while awake");
	deep_kind_a: assert property (asleep |-> keepAssoc != deepSleep) else $error("sleep kind");
	sleep_hold_a: assert property (asleep |-> hostHold) else $error("no hold");
	drain_first_a: assert property ($rose(asleep) |-> !$past(workPending)) else $error("slept busy");
	period_range_a: assert property (rdRange(3'h1, 24'h1, 24'h83d600)) else $error("period");
	wake_range_a: assert property (rdRange(3'h4, 24'h1, 24'h36ee80)) else $error("wake");
	join_range_a: assert property (rdRange(3'h5, 24'h1, 24'h36ee80)) else $error("join");
	opt_fixed_a: assert property ($past(rstn) && $past(cfgSel) == 3'h2 |-> cfgRdata[23:8] == 16'h1)
		else $error("options");
	mode_code_a: assert property ($past(rstn) && $past(cfgSel) == 3'h0
		|-> cfgRdata inside {24'h0, 24'h1, 24'h4, 24'h5}) else $error("mode");
	char_stop_a: assert property (hostChar && hostHold && !asleep |-> ##[1:2] !hostHold) else $error("char");
	commit_only_a: assert property ($past(rstn) && !cfgApply && !$past(cfgApply) && $stable(cfgSel)
		|=> $stable(cfgRdata)) else $error("uncommitted");
	cover property ($rose(asleep));
	cover property ($fell(asleep) ##1 hostHold);
	cover property (hostChar && hostHold && !asleep);
endmodule : swt_ctrl_monitor
bind swt_ctrl swt_ctrl_monitor #(.MS_CYCLES(MS_CYCLES)) i_swt_ctrl_monitor(.ref_clk(ref_clk), .rstn(rstn),
	.cfgWrite(cfgWrite), .cfgSel(cfgSel), .cfgData(cfgData), .cfgApply(cfgApply), .cfgRdata(cfgRdata),
	.sleepPin(sleepPin), .hostChar(hostChar), .workPending(workPending), .associated(associated),
	.asleep(asleep), .keepAssoc(keepAssoc), .hostHold(hostHold), .deepSleep(deepSleep));

// [swt_ctrl_tb_top.sv]
// Self-checking testbench of the sleep and wake timing controller
`timescale 1ns/100ps
module swt_ctrl_tb_top;
	logic ref_clk = 0, rstn = 0, reqWr = 0, reqApply = 0, reqChar = 0, sleepPin = 0, workPending = 0, associated = 0;
	logic [2:0] reqSel = 3'h0, rs;
	logic [23:0] reqData = 24'h0, lfsr = 24'h00000b, v;
	logic cfgWrite, cfgApply, hostChar, asleep, keepAssoc, hostHold, deepSleep;
	logic [2:0] cfgSel;
	logic [23:0] cfgData, cfgRdata;
	logic [7:0] modes [5] = '{8'h01, 8'h04, 8'h05, 8'h02, 8'h00};
	int errors = 0, comparisons = 0, n;
	swt_host_model i_swt_host_model(.ref_clk(ref_clk), .reqWr(reqWr), .reqApply(reqApply), .reqChar(reqChar),
		.reqSel(reqSel), .reqData(reqData), .cfgWrite(cfgWrite), .cfgApply(cfgApply), .hostChar(hostChar),
		.cfgSel(cfgSel), .cfgData(cfgData));
	// Short millisecond keeps the run brief
	swt_ctrl #(.MS_CYCLES(20)) i_swt_ctrl(.ref_clk(ref_clk), .rstn(rstn), .cfgWrite(cfgWrite), .cfgSel(cfgSel),
		.cfgData(cfgData), .cfgApply(cfgApply), .cfgRdata(cfgRdata), .sleepPin(sleepPin), .hostChar(hostChar),
		.workPending(workPending), .associated(associated), .asleep(asleep), .keepAssoc(keepAssoc),
		.hostHold(hostHold), .deepSleep(deepSleep));
	initial
	begin
		forever #12.5 ref_clk = ~ref_clk;
	end
	// -------
	// Helpers
	// -------
	function automatic logic [23:0] lfsrNext(logic [23:0] x);
		return {x[22:0], x[23] ^ x[22] ^ x[21] ^ x[16]};
	endfunction : lfsrNext
	function automatic logic [23:0] lim(logic [23:0] d, logic [23:0] mx);
		return (d == 24'h0) ? 24'h000001 : ((d > mx) ? mx : d);
	endfunction : lim
	function automatic logic [23:0] expv(logic [2:0] s, logic [23:0] d);
		case (s)
			3'h0: return d;
			3'h1: return lim(d, 24'h83d600);
			3'h2: return (d & 24'h0000ff) | 24'h000100;
			3'h3: return d & 24'h00ffff;
			default: return lim(d, 24'h36ee80);
		endcase
	endfunction : expv
	function automatic logic [23:0] rstv(logic [2:0] s);
		case (s)
			3'h1: return 24'h0000c8;
			3'h2: return 24'h000100;
			3'h4: return 24'h0007d0;
			3'h5: return 24'h002710;
			default: return 24'h000000;
		endcase
	endfunction : rstv
	task automatic chk(string nm, logic [23:0] e, logic [23:0] s);
		comparisons++;
		if (s !== e)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic wr(logic [2:0] s, logic [23:0] d, logic ap);
		@(posedge ref_clk);
		reqWr <= 1'b1;
		reqSel <= s;
		reqData <= d;
		@(posedge ref_clk);
		reqWr <= 1'b0;
		reqApply <= ap;
		@(posedge ref_clk);
		reqApply <= 1'b0;
	endtask : wr
	task automatic rd(logic [2:0] s);
		@(posedge ref_clk);
		reqSel <= s;
		repeat (4) @(posedge ref_clk);
		#1 v = cfgRdata;
	endtask : rd
	task automatic wrc(logic [2:0] s, logic [23:0] d);
		wr(s, d, 1'b1);
		rd(s);
		chk("setting", expv(s, d), v);
	endtask : wrc
	task automatic waitAs(logic x, int lm);
		n = 0;
		while (asleep !== x && n < lm)
		begin
			@(posedge ref_clk);
			#1 n++;
		end
	endtask : waitAs
	task automatic end_of_test;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test
	initial
	begin
		repeat (70000) @(posedge ref_clk);
		errors++;
		end_of_test();
	end
	// --------
	// Sequence
	// --------
	initial
	begin
		repeat (16) @(posedge ref_clk);
		rstn <= 1'b1;
		for (int s = 0; s < 6; s++)
		begin
			rd(3'(s));
			chk("resetValue", rstv(3'(s)), v);
		end
		wr(3'h4, 24'h000005, 1'b0);
		rd(3'h4);
		chk("pendingWake", 24'h0007d0, v);
		wrc(3'h4, 24'h000005);
		foreach (modes[i])
		begin
			wr(3'h0, {16'h0, modes[i]}, 1'b1);
			rd(3'h0);
			chk("mode", (modes[i] == 8'h02) ? 24'h000005 : {16'h0, modes[i]}, v);
		end
		wrc(3'h1, 24'h000000);
		wrc(3'h4, 24'h36ee81);
		repeat (10)
		begin
			lfsr = lfsrNext(lfsr);
			rs = 3'(8'h01 + lfsr[7:0] % 8'h05);
			wrc(rs, lfsr);
		end
		@(posedge ref_clk);
		associated <= 1'b1;
		wrc(3'h4, 24'h000002);
		wrc(3'h1, 24'h000002);
		wrc(3'h2, 24'h000140);
		wrc(3'h3, 24'h000003);
		wrc(3'h5, 24'h000003);
		wrc(3'h0, 24'h000004);
		waitAs(1'b1, 42000);
		chk("keepAssoc", 24'h000003, {22'h0, keepAssoc, asleep});
		waitAs(1'b0, 500);
		chk("sleepLen", 24'h000001, 24'(n >= 190 && n <= 420));
		chk("hostHold", 24'h000001, 24'(hostHold));
		@(posedge ref_clk);
		reqChar <= 1'b1;
		workPending <= 1'b1;
		@(posedge ref_clk);
		reqChar <= 1'b0;
		repeat (4) @(posedge ref_clk);
		chk("charStop", 24'h000000, 24'(hostHold));
		repeat (200) @(posedge ref_clk);
		chk("drainWait", 24'h000000, 24'(asleep));
		workPending <= 1'b0;
		waitAs(1'b1, 30);
		chk("drainDone", 24'h000001, 24'(asleep));
		wrc(3'h2, 24'h000100);
		wrc(3'h0, 24'h000001);
		waitAs(1'b0, 500);
		@(posedge ref_clk);
		sleepPin <= 1'b1;
		waitAs(1'b1, 120);
		chk("pinSleep", 24'h000003, {22'h0, deepSleep, asleep});
		@(posedge ref_clk);
		sleepPin <= 1'b0;
		waitAs(1'b0, 60);
		chk("pinWake", 24'h000000, 24'(asleep));
		wrc(3'h0, 24'h000000);
		@(posedge ref_clk);
		sleepPin <= 1'b1;
		repeat (600) @(posedge ref_clk);
		chk("noSleep", 24'h000000, 24'(asleep));
		associated <= 1'b0;
		wrc(3'h0, 24'h000004);
		waitAs(1'b1, 200);
		chk("joinGiveUp", 24'h000003, {22'h0, deepSleep, asleep});
		end_of_test();
	end
endmodule : swt_ctrl_tb_top
